// >>> dom_pkg.sv
// shared constants for the discrete output point mapping link
package dom_pkg;
    localparam int W = 16;
    localparam int N8 = 8;
    localparam int N12 = 12;
    // link operations
    typedef enum logic [2:0] {
        OP_WR_COIL = 3'h0,
        OP_WR_HOLD = 3'h1,
        OP_RD_INBIT = 3'h2,
        OP_RD_INWORD = 3'h3,
        OP_RD_STATUS = 3'h4,
        OP_WR_CFG = 3'h5
    } dom_op_e;
    // configuration word selected by idx of a config write
    localparam logic [3:0] CFG_MODE = 4'h0;
    localparam logic [3:0] CFG_PATTERN = 4'h1;
    // mode word fields
    localparam int MB_OUT_WORD = 0;
    localparam int MB_OUT_BCD = 1;
    localparam int MB_TO_USER = 2;
    localparam int MB_IN_WORD = 3;
    localparam int MB_IN_BCD = 4;
    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic [11:0] PATTERN_RST = 12'h000;
    localparam int SB_MOD_FAULT = 0;
    // host register offsets
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_RESP = 8'h04;
    localparam logic [7:0] A_CTRL = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_MASK = 8'h10;
    // command register fields
    localparam int CF_IDX = 16;
    localparam int CF_OP = 20;
    // status bits
    localparam int ST_DONE = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_FAULT = 2;
    localparam int ST_BUSY = 8;
endpackage

// >>> dom_link_if.sv
// backplane link between scanner and output module
`timescale 1ns/1ns
interface dom_link_if;
    import dom_pkg::*;
    logic sys_ctrl;
    logic req;
    dom_op_e op;
    logic [3:0] idx;
    logic [W-1:0] wdata;
    logic ack;
    logic err;
    logic [W-1:0] rdata;
    modport dev (input sys_ctrl, req, op, idx, wdata, output ack, err, rdata);
    modport host (output sys_ctrl, req, op, idx, wdata, input ack, err, rdata);
endinterface

// >>> dom_bcd.sv
// four-digit bcd to binary and binary to bcd converters
`timescale 1ns/1ns
module dom_bcd
    import dom_pkg::*;
(
    input wire logic [W-1:0] bcd_in,
    input wire logic [N12-1:0] bin_in,
    output logic [W-1:0] bin_out,
    output logic [W-1:0] bcd_out
);
    // digits above 9 are taken at face value; software must write legal bcd
    always_comb begin
        bin_out = W'(bcd_in[15:12]) * W'(1000) + W'(bcd_in[11:8]) * W'(100)
            + W'(bcd_in[7:4]) * W'(10) + W'(bcd_in[3:0]);
    end

    // double dabble over the twelve fault bits
    always_comb begin
        logic [W+N12-1:0] sh;
        sh = {W'(0), bin_in};
        for (int i = 0; i < N12; i++) begin
            for (int d = 0; d < 4; d++) begin
                if (sh[N12 + 4*d +: 4] > 4'h4) begin
                    sh[N12 + 4*d +: 4] = sh[N12 + 4*d +: 4] + 4'h3;
                end
            end
            sh = sh << 1;
        end
        bcd_out = sh[W+N12-1:N12];
    end
endmodule

// >>> dom_device.sv
// output module end: point map, timeout state and fault latching
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ns
module dom_device
    import dom_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    dom_link_if.dev link,
    input wire logic twelve_pt,
    input wire logic [N12-1:0] fault_in,
    output logic [N12-1:0] point_out,
    output logic module_fault
);
    logic tw_meta;
    logic tw;
    logic [N12-1:0] flt_meta;
    logic [N12-1:0] flt;
    logic [4:0] mode;
    logic [N12-1:0] pattern;
    logic [N12-1:0] cmd;
    logic [N12-1:0] fault_lat;
    logic [W-1:0] hold_bin;
    logic [W-1:0] fault_bcd;
    logic [N12-1:0] next_cmd;
    logic [N12-1:0] wr_mask;
    logic wr_ok;
    logic refuse;
    logic [W-1:0] rd_val;
    logic [N12-1:0] pt_mask;

    // pins come from the field side, two stages before use
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tw_meta <= 1'b0;
            tw <= 1'b0;
            flt_meta <= '0;
            flt <= '0;
        end else begin
            tw_meta <= twelve_pt;
            tw <= tw_meta;
            flt_meta <= fault_in;
            flt <= flt_meta;
        end
    end

    assign pt_mask = tw ? {N12{1'b1}} : N12'(8'hFF);

    dom_bcd i_dom_bcd (
        .bcd_in(link.wdata),
        .bin_in(fault_lat),
        .bin_out(hold_bin),
        .bcd_out(fault_bcd)
    );

    // decode one link request: legality, new command value, read data
    always_comb begin
        refuse = 1'b0;
        wr_ok = 1'b0;
        next_cmd = cmd;
        rd_val = '0;
        unique case (link.op)
            OP_WR_COIL: begin
                // bit form only on the eight-point module
                if (tw || mode[MB_OUT_WORD] || link.idx >= 4'(N8)) begin
                    refuse = 1'b1;
                end else begin
                    wr_ok = 1'b1;
                    next_cmd[link.idx] = link.wdata[0];
                end
            end
            OP_WR_HOLD: begin
                if (!tw && !mode[MB_OUT_WORD]) begin
                    refuse = 1'b1;
                end else begin
                    wr_ok = 1'b1;
                    next_cmd = (mode[MB_OUT_BCD] ? hold_bin[N12-1:0]
                        : link.wdata[N12-1:0]) & pt_mask;
                end
            end
            OP_RD_INBIT: begin
                // twelve fault points padded to sixteen bit references
                if (!tw || mode[MB_IN_WORD]) begin
                    refuse = 1'b1;
                end else begin
                    rd_val = W'(fault_lat[link.idx[3:0] < 4'(N12) ? link.idx : 4'h0]
                        & (link.idx < 4'(N12)));
                end
            end
            OP_RD_INWORD: begin
                if (!tw || !mode[MB_IN_WORD]) begin
                    refuse = 1'b1;
                end else begin
                    rd_val = mode[MB_IN_BCD] ? fault_bcd : W'(fault_lat);
                end
            end
            OP_RD_STATUS: begin
                if (!tw) begin
                    refuse = 1'b1;
                end else begin
                    rd_val = W'(|fault_lat) << SB_MOD_FAULT;
                end
            end
            OP_WR_CFG: begin
                refuse = (link.idx != CFG_MODE) && (link.idx != CFG_PATTERN);
            end
            default: begin
                refuse = 1'b1;
            end
        endcase
        // coil and hold writes are refused while control is stopped, so cmd stays the last value
        if (!link.sys_ctrl && (link.op == OP_WR_COIL || link.op == OP_WR_HOLD)) begin
            refuse = 1'b1;
            wr_ok = 1'b0;
            next_cmd = cmd;
        end
    end

    // per-point written-off mask for fault clearing
    assign wr_mask = (link.req && wr_ok) ? ~next_cmd & pt_mask : '0;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= '0;
        end else if (link.req && wr_ok) begin
            cmd <= next_cmd;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode <= MODE_RST;
            pattern <= PATTERN_RST;
        end else if (link.req && link.op == OP_WR_CFG) begin
            if (link.idx == CFG_MODE) begin
                mode <= link.wdata[4:0];
                // input bcd only exists with the word-wide input map
                mode[MB_IN_BCD] <= link.wdata[MB_IN_BCD] && link.wdata[MB_IN_WORD];
                if (tw) begin
                    mode[MB_OUT_WORD] <= 1'b1;
                end
            end else if (link.idx == CFG_PATTERN) begin
                pattern <= link.wdata[N12-1:0] & pt_mask;
            end
        end
    end

    // a new fault in the same cycle as an off command stays latched
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fault_lat <= '0;
        end else begin
            fault_lat <= ((fault_lat & ~wr_mask) | flt) & {N12{tw}};
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            point_out <= '0;
        end else if (link.sys_ctrl) begin
            point_out <= cmd & pt_mask;
        end else begin
            point_out <= (mode[MB_TO_USER] ? pattern : cmd) & pt_mask;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            module_fault <= 1'b0;
        end else begin
            module_fault <= |fault_lat;
        end
    end

    // one answer per request, the cycle after it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link.ack <= 1'b0;
            link.err <= 1'b0;
            link.rdata <= '0;
        end else begin
            link.ack <= link.req;
            link.err <= link.req && refuse;
            link.rdata <= (link.req && !refuse) ? rd_val : '0;
        end
    end
endmodule

// >>> dom_host.sv
// scanner end: software registers driving link requests
`timescale 1ns/1ns
module dom_host
    import dom_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    dom_link_if.host link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic irq
);
    logic busy;
    logic [W-1:0] resp;
    logic resp_err;
    logic [2:0] stat;
    logic [2:0] mask;
    logic [2:0] set_ev;
    logic [31:0] next_rdata;
    logic cmd_go;

    assign cmd_go = wr && addr == A_CMD && !busy;

    // one request in flight; commands written while busy are dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy <= 1'b0;
            link.req <= 1'b0;
            link.op <= OP_WR_COIL;
            link.idx <= '0;
            link.wdata <= '0;
        end else begin
            link.req <= cmd_go;
            if (cmd_go) begin
                busy <= 1'b1;
                link.op <= dom_op_e'(wdata[CF_OP +: 3]);
                link.idx <= wdata[CF_IDX +: 4];
                link.wdata <= wdata[W-1:0];
                // bcd fault word misreports faults, so the host never asks for it
                if (dom_op_e'(wdata[CF_OP +: 3]) == OP_WR_CFG
                    && wdata[CF_IDX +: 4] == CFG_MODE) begin
                    link.wdata[MB_IN_BCD] <= 1'b0;
                end
            end else if (link.ack) begin
                busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            link.sys_ctrl <= 1'b0;
        end else if (wr && addr == A_CTRL) begin
            link.sys_ctrl <= wdata[0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            resp <= '0;
            resp_err <= 1'b0;
        end else if (link.ack) begin
            resp <= link.rdata;
            resp_err <= link.err;
        end
    end

    always_comb begin
        set_ev = '0;
        set_ev[ST_DONE] = link.ack;
        set_ev[ST_REFUSED] = link.ack && link.err;
        set_ev[ST_FAULT] = link.ack && !link.err && link.op == OP_RD_STATUS
            && link.rdata[SB_MOD_FAULT];
    end

    // set wins over a same-cycle write-one clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat <= '0;
        end else if (wr && addr == A_STAT) begin
            stat <= (stat & ~wdata[2:0]) | set_ev;
        end else begin
            stat <= stat | set_ev;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mask <= '0;
        end else if (wr && addr == A_MASK) begin
            mask <= wdata[2:0];
        end
    end

    always_comb begin
        next_rdata = '0;
        unique case (addr)
            A_RESP: next_rdata = {15'h0000, resp_err, resp};
            A_CTRL: next_rdata = {31'h00000000, link.sys_ctrl};
            A_STAT: next_rdata = {23'h000000, busy, 5'h00, stat};
            A_MASK: next_rdata = {29'h00000000, mask};
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= '0;
        end else begin
            rdata <= rd ? next_rdata : '0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat & mask);
        end
    end
endmodule

// >>> dom_link_chk.sv
// link checker: answer timing, refusals, point and fault outputs
`timescale 1ns/1ns
module dom_link_chk
    import dom_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sys_ctrl,
    input wire logic req,
    input wire dom_op_e op,
    input wire logic [3:0] idx,
    input wire logic [W-1:0] wdata,
    input wire logic ack,
    input wire logic err,
    input wire logic [W-1:0] rdata,
    input wire logic twelve_pt,
    input wire logic [N12-1:0] fault_in,
    input wire logic [N12-1:0] point_out,
    input wire logic module_fault
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_ack; req |=> ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_ack_cause; ack |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_rd_idle; !ack |-> rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside ack");
    property p_no_stat8; req && op == OP_RD_STATUS && !twelve_pt |=> err; endproperty
    a_no_stat8: assert property (p_no_stat8) else $error("status given on 8 points");
    property p_coil12; req && op == OP_WR_COIL && twelve_pt |=> err; endproperty
    a_coil12: assert property (p_coil12) else $error("bit write on 12 points");
    property p_stop; req && (op == OP_WR_COIL || op == OP_WR_HOLD) && !sys_ctrl |=> err;
    endproperty
    a_stop: assert property (p_stop) else $error("write taken without control");
    property p_inword8; req && op == OP_RD_INWORD && !twelve_pt |=> err; endproperty
    a_inword8: assert property (p_inword8) else $error("fault word on 8 points");
    // sync stages need a few cycles before the module kind settles
    property p_hi8; (!twelve_pt) [*4] |-> point_out[11:8] == 4'h0; endproperty
    a_hi8: assert property (p_hi8) else $error("upper points driven on 8 points");
    property p_ff8; (!twelve_pt) [*4] |-> !module_fault; endproperty
    a_ff8: assert property (p_ff8) else $error("module fault on 8 points");
    property p_fault; (twelve_pt && fault_in != 12'h000) [*6] |-> module_fault; endproperty
    a_fault: assert property (p_fault) else $error("fault flag not raised");
    // a latched fault only drops two edges after a write request was taken
    property p_fault_clr; $fell(module_fault) |-> $past(req, 2); endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("fault cleared early");
endmodule

// >>> dom_tb.sv
// testbench: software port to output points across the link
`timescale 1ns/1ns
module dom_tb
    import dom_pkg::*;
;
    logic clk_sys, rst_n, wr, rd, irq, twelve_pt, module_fault;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, resp;
    logic [11:0] fault_in, point_out;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    dom_link_if link ();
    dom_host i_dom_host (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
    dom_device i_dom_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
        .twelve_pt(twelve_pt), .fault_in(fault_in), .point_out(point_out),
        .module_fault(module_fault));
    dom_link_chk i_dom_link_chk (.clk_sys(clk_sys), .rst_n(rst_n), .sys_ctrl(link.sys_ctrl),
        .req(link.req), .op(link.op), .idx(link.idx), .wdata(link.wdata), .ack(link.ack),
        .err(link.err), .rdata(link.rdata), .twelve_pt(twelve_pt), .fault_in(fault_in),
        .point_out(point_out), .module_fault(module_fault));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // the whole run needs well under this many cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end
    task results;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 resp = rdata;
    endtask
    // waits out busy, then fetches the answer word
    task cmd(input logic [2:0] o, input logic [3:0] i, input logic [15:0] d);
        wr_reg(A_CMD, {9'h000, o, i, d});
        repeat (4) @(posedge clk_sys);
        rd_reg(A_RESP);
    endtask
    // module kind is a pin, so it only changes under reset
    task do_reset(input logic t12);
        rst_n <= 1'b0;
        twelve_pt <= t12;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        wr_reg(A_CTRL, 32'h0000_0001);
    endtask
    task t_map8;
        cmd(OP_WR_CFG, CFG_MODE, 16'h0000);
        cmd(OP_WR_COIL, 4'h3, 16'h0001);
        chk(point_out, 12'h008);
        cmd(OP_WR_COIL, 4'h7, 16'h0001);
        chk(point_out, 12'h088);
        cmd(OP_WR_HOLD, 4'h0, 16'h00FF);
        chk(resp[16], 1'b1);
        cmd(OP_WR_CFG, CFG_MODE, 16'h0001);
        cmd(OP_WR_HOLD, 4'h0, 16'h00A5);
        chk(point_out, 12'h0A5);
        cmd(OP_WR_COIL, 4'h0, 16'h0001);
        chk(resp[16], 1'b1);
        cmd(OP_RD_STATUS, 4'h0, 16'h0000);
        chk(resp[16], 1'b1);
        cmd(OP_WR_CFG, CFG_MODE, 16'h0003);
        cmd(OP_WR_HOLD, 4'h0, 16'h0042);
        chk(point_out, 12'h02A);
        $display("test map8 done");
    endtask
    task t_timeout;
        cmd(OP_WR_CFG, CFG_MODE, 16'h0005);
        wr_reg(A_CTRL, 32'h0000_0000);
        repeat (3) @(posedge clk_sys);
        #1 chk(point_out, 12'h000);
        cmd(OP_WR_HOLD, 4'h0, 16'h0011);
        chk(resp[16], 1'b1);
        cmd(OP_WR_CFG, CFG_PATTERN, 16'h0FFF);
        chk(point_out, 12'h0FF);
        cmd(OP_WR_CFG, CFG_MODE, 16'h0001);
        chk(point_out, 12'h02A);
        wr_reg(A_CTRL, 32'h0000_0001);
        cmd(OP_WR_HOLD, 4'h0, 16'h0033);
        chk(point_out, 12'h033);
        $display("test timeout done");
    endtask
    task t_twelve;
        @(posedge clk_sys);
        do_reset(1'b1);
        cmd(OP_WR_COIL, 4'h0, 16'h0001);
        chk(resp[16], 1'b1);
        cmd(OP_WR_HOLD, 4'h0, 16'hFFFF);
        chk(point_out, 12'hFFF);
        @(posedge clk_sys);
        fault_in <= 12'h00C;
        repeat (8) @(posedge clk_sys);
        fault_in <= 12'h000;
        cmd(OP_RD_STATUS, 4'h0, 16'h0000);
        chk(resp[16:0], 17'h00001);
        cmd(OP_RD_INBIT, 4'h2, 16'h0000);
        chk(resp[16:0], 17'h00001);
        cmd(OP_RD_INWORD, 4'h0, 16'h0000);
        chk(resp[16], 1'b1);
        cmd(OP_WR_CFG, CFG_MODE, 16'h0009);
        cmd(OP_RD_INWORD, 4'h0, 16'h0000);
        chk(resp[16:0], 17'h0000C);
        // asking for the bcd fault word must still return plain binary
        cmd(OP_WR_CFG, CFG_MODE, 16'h0019);
        cmd(OP_RD_INWORD, 4'h0, 16'h0000);
        chk(resp[16:0], 17'h0000C);
        cmd(OP_RD_INBIT, 4'h2, 16'h0000);
        chk(resp[16], 1'b1);
        cmd(OP_WR_HOLD, 4'h0, 16'h0004);
        chk(module_fault, 1'b1);
        cmd(OP_WR_HOLD, 4'h0, 16'h0000);
        chk(module_fault, 1'b0);
        cmd(OP_WR_CFG, CFG_MODE, 16'h0005);
        wr_reg(A_CTRL, 32'h0000_0000);
        cmd(OP_WR_CFG, CFG_PATTERN, 16'h0FFF);
        chk(point_out, 12'hFFF);
        $display("test twelve done");
    endtask
    // only the module fault bit is unmasked, so done alone must not interrupt
    task t_irq;
        wr_reg(A_STAT, 32'h0000_0007);
        wr_reg(A_MASK, 32'h0000_0004);
        cmd(OP_RD_STATUS, 4'h0, 16'h0000);
        chk(irq, 1'b0);
        @(posedge clk_sys);
        fault_in <= 12'h001;
        repeat (8) @(posedge clk_sys);
        fault_in <= 12'h000;
        cmd(OP_RD_STATUS, 4'h0, 16'h0000);
        chk(irq, 1'b1);
        wr_reg(A_STAT, 32'h0000_0004);
        repeat (2) @(posedge clk_sys);
        #1 chk(irq, 1'b0);
        rd_reg(A_CTRL);
        chk(resp, 32'h0000_0000);
        $display("test irq done");
    endtask
    initial begin
        rst_n = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        twelve_pt = 1'b0;
        fault_in = 12'h000;
        do_reset(1'b0);
        t_map8();
        t_timeout();
        t_twelve();
        t_irq();
        results();
    end
endmodule
